// ---- src/ssm_policy.sv ----
// Forwarding policy: tree-state gating, snooping traps and port mirroring.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ssm_cfg.svh"
module ssm_policy
   import ssm_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Lookup request: one packet described per valid cycle.
   input wire logic req_valid,
   input wire logic [1:0] req_src,
   input wire logic [2:0] req_lookup_ports,
   input wire logic req_static_hit,
   input wire logic req_static_override,
   input wire logic [2:0] req_static_ports,
   input wire logic req_multicast,
   input wire logic req_bad,
   input wire logic req_ipv4,
   input wire logic [3:0] req_ip_version,
   input wire logic [7:0] req_ip_protocol,
   input wire logic req_ipv6,
   input wire logic [7:0] req_hop_limit,
   input wire logic [7:0] req_next_header,
   input wire logic [7:0] req_hbh_next_header,
   // Decision, registered one cycle after the request.
   output logic dec_valid,
   output logic [2:0] dec_ports,
   output logic dec_learn,
   output logic dec_trapped,
   output logic dec_mirrored,
   output logic [1:0] rx_source_port_field
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] port_one_control_two_reg;
   logic [31:0] port_two_control_two_reg;
   logic [31:0] host_port_control_two_reg;
   logic [31:0] switch_global_control_two_reg;
   logic [15:0] trap_count_reg;
   logic [31:0] prdata_reg;
   logic dec_valid_reg;
   logic [2:0] dec_ports_reg;
   logic dec_learn_reg;
   logic dec_trapped_reg;
   logic dec_mirrored_reg;
   logic [1:0] src_field_reg;

   function automatic ssm_stp_t stp_of(input logic [31:0] cr);
      logic [2:0] b;
      b = {cr[`SSM_BIT_TXEN], cr[`SSM_BIT_RXEN], cr[`SSM_BIT_LRNDIS]};
      unique case (b)
         3'b001: stp_of = SSM_ST_BLOCK;
         3'b000: stp_of = SSM_ST_LEARN;
         3'b110: stp_of = SSM_ST_FWD;
         default: stp_of = SSM_ST_ODD;
      endcase
   endfunction : stp_of

   function automatic logic mld_hdr(input logic [7:0] nh,
                                    input logic opt);
      mld_hdr = (nh == 8'h01) || (nh == 8'h3a) ||
         (opt && ((nh == 8'h2b) || (nh == 8'h2c) || (nh == 8'h32) ||
                  (nh == 8'h33) || (nh == 8'h3c)));
   endfunction : mld_hdr

   ////////////////////////////////////////////////////////////////////////
   // APB decode. Every access completes in its first access cycle.
   wire apb_wr = psel && penable && pwrite;
   wire hit_p1 = paddr == `SSM_OFF_PONE_CTL;
   wire hit_p2 = paddr == `SSM_OFF_PTWO_CTL;
   wire hit_hp = paddr == `SSM_OFF_HPCR2;
   wire hit_gc = paddr == `SSM_OFF_GCR2;
   wire hit_st = paddr == `SSM_OFF_STAT;
   wire mapped = hit_p1 || hit_p2 || hit_hp || hit_gc || hit_st;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   wire [31:0] rd_mux = hit_p1 ? port_one_control_two_reg :
                        hit_p2 ? port_two_control_two_reg :
                        hit_hp ? host_port_control_two_reg :
                        hit_gc ? switch_global_control_two_reg :
                        hit_st ? {16'h0000, trap_count_reg} :
                        32'h0000_0000;

   // Read data is captured in the setup cycle, so it comes from a flip-flop
   // and the access still needs no wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_reg <= rd_mux;
      end
   end
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_one_control_two_reg <= `SSM_RST_PCR2;
         port_two_control_two_reg <= `SSM_RST_PCR2;
         host_port_control_two_reg <= `SSM_RST_PCR2;
         switch_global_control_two_reg <= `SSM_RST_GCR2;
      end else if (apb_wr) begin
         if (hit_p1) port_one_control_two_reg <= pwdata;
         if (hit_p2) port_two_control_two_reg <= pwdata;
         if (hit_hp) host_port_control_two_reg <= pwdata;
         if (hit_gc) switch_global_control_two_reg <= pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port selections, indexed by port number (bit 2 is the host).
   wire [2:0] rx_sniff = {host_port_control_two_reg[`SSM_BIT_RXSNIFF],
      port_two_control_two_reg[`SSM_BIT_RXSNIFF],
      port_one_control_two_reg[`SSM_BIT_RXSNIFF]};
   wire [2:0] tx_sniff = {host_port_control_two_reg[`SSM_BIT_TXSNIFF],
      port_two_control_two_reg[`SSM_BIT_TXSNIFF],
      port_one_control_two_reg[`SSM_BIT_TXSNIFF]};
   wire [2:0] sniffer = {host_port_control_two_reg[`SSM_BIT_SNIFFER],
      port_two_control_two_reg[`SSM_BIT_SNIFFER],
      port_one_control_two_reg[`SSM_BIT_SNIFFER]};
   wire and_mode = switch_global_control_two_reg[`SSM_BIT_AND];
   wire bad_mirror = switch_global_control_two_reg[`SSM_BIT_BADMIR];
   wire mld_en = switch_global_control_two_reg[`SSM_BIT_MLDEN];
   wire mld_opt = switch_global_control_two_reg[`SSM_BIT_MLDOPT];

   // The host port has no tree state and always passes traffic.
   wire [2:0] tx_ok = {1'b1,
      port_two_control_two_reg[`SSM_BIT_TXEN],
      port_one_control_two_reg[`SSM_BIT_TXEN]};
   wire [2:0] rx_ok = {1'b1,
      port_two_control_two_reg[`SSM_BIT_RXEN],
      port_one_control_two_reg[`SSM_BIT_RXEN]};
   wire [2:0] lrn_ok = {1'b0,
      !port_two_control_two_reg[`SSM_BIT_LRNDIS],
      !port_one_control_two_reg[`SSM_BIT_LRNDIS]};
   wire [2:0] src_1h = (req_src == SSM_PORT_P1) ? 3'b001 :
                       (req_src == SSM_PORT_P2) ? 3'b010 : 3'b100;
   wire from_host = src_1h[2];
   wire src_rx_ok = |(src_1h & rx_ok);
   ssm_stp_t p1_state;
   assign p1_state = stp_of(port_one_control_two_reg);

   ////////////////////////////////////////////////////////////////////////
   // Snooping traps.
   wire igmp_hit = req_ipv4 && (req_ip_version == `SSM_IPV4) &&
      (req_ip_protocol == `SSM_PROT_IGMP);
   wire mld_nh = mld_hdr(req_next_header, mld_opt) ||
      ((req_next_header == 8'h00) &&
       mld_hdr(req_hbh_next_header, mld_opt));
   wire mld_hit = mld_en && req_ipv6 && req_multicast &&
      (req_hop_limit == 8'h01) && mld_nh;
   wire trap = !from_host && (igmp_hit || mld_hit);

   // Normal destination before tree-state gating.
   wire mc_static = req_multicast && req_static_hit;
   wire [2:0] base_dst = mc_static ? req_static_ports
                                   : req_lookup_ports;
   // Traffic from a port that is not receiving only reaches the host, and
   // only through an override entry or a trap; host frames go to any listed network port that is transmitting.
   wire [2:0] gated_dst = from_host ? (base_dst & tx_ok & ~3'b100) :
      src_rx_ok ? (base_dst & tx_ok & ~src_1h) :
      3'b000;
   wire ovr_host = !from_host && req_static_hit && req_static_override &&
      req_static_ports[2];
   wire [2:0] norm_dst = trap ? 3'b100 :
      (gated_dst | (ovr_host ? 3'b100 : 3'b000));

   // Mirroring is checked against the normal destination, traps and overrides included.
   wire rx_m = |(src_1h & rx_sniff);
   wire tx_m = |(norm_dst & tx_sniff);
   wire mir_sel = and_mode ? (rx_m && tx_m) : (rx_m || tx_m);
   wire mir_go = mir_sel && (!req_bad || bad_mirror);
   wire good = !req_bad;
   wire [2:0] pass_dst = good ? norm_dst : 3'b000;
   // OR merges the copy, so a sniffer already on the list gets one frame.
   wire [2:0] final_dst = pass_dst | (mir_go ? sniffer : 3'b000);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_valid_reg <= 1'b0;
         dec_ports_reg <= 3'b000;
         dec_learn_reg <= 1'b0;
         dec_trapped_reg <= 1'b0;
         dec_mirrored_reg <= 1'b0;
         src_field_reg <= 2'b00;
         trap_count_reg <= 16'h0000;
      end else begin
         dec_valid_reg <= req_valid;
         if (req_valid) begin
            dec_ports_reg <= final_dst;
            dec_learn_reg <= good && |(src_1h & lrn_ok);
            dec_trapped_reg <= trap;
            dec_mirrored_reg <= mir_go;
            src_field_reg <= (req_src == SSM_PORT_P1) ? `SSM_SRC_P1 :
               (req_src == SSM_PORT_P2) ? `SSM_SRC_P2 : 2'b00;
            if (trap) trap_count_reg <= trap_count_reg + 16'h0001;
         end
      end
   end

   assign dec_valid = dec_valid_reg;
   assign dec_ports = dec_ports_reg;
   assign dec_learn = dec_learn_reg;
   assign dec_trapped = dec_trapped_reg;
   assign dec_mirrored = dec_mirrored_reg;
   assign rx_source_port_field = src_field_reg;

   ////////////////////////////////////////////////////////////////////////
   property p_trap_host;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && trap && !mir_go) |=> (dec_ports == 3'b100);
   endproperty
   a_trap_host: assert property (p_trap_host)
      else $error("trapped frame left for a non-host port");

   property p_mld_off;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && !mld_en && !igmp_hit) |=> !dec_trapped;
   endproperty
   a_mld_off: assert property (p_mld_off)
      else $error("trap without enable");

   property p_disabled_tx;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && !tx_ok[0] && !mir_go) |=> !dec_ports[0];
   endproperty
   a_disabled_tx: assert property (p_disabled_tx)
      else $error("port one sent while transmit disabled");

   property p_no_learn;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && p1_state == SSM_ST_BLOCK && req_src == SSM_PORT_P1)
      |=> !dec_learn;
   endproperty
   a_no_learn: assert property (p_no_learn)
      else $error("learned in blocking state");

   property p_override;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && ovr_host && good) |=> dec_ports[2];
   endproperty
   a_override: assert property (p_override)
      else $error("override entry not sent to host");

   property p_mirror;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && mir_go) |=> ((dec_ports & sniffer) == sniffer);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("mirror copy missing");

   property p_and;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && and_mode && !rx_m) |=> !dec_mirrored;
   endproperty
   a_and: assert property (p_and)
      else $error("and mode mirrored without rx sniff");

   property p_src;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && req_src == SSM_PORT_P2) |=>
      (rx_source_port_field == 2'b10) && dec_valid;
   endproperty
   a_src: assert property (p_src)
      else $error("wrong source port code");

   ////////////////////////////////////////////////////////////////////////
   // Register access checks built from bus phases, then further decision checks.
   sequence s_apb_access;
      psel && penable;
   endsequence

   sequence s_rd_setup;
      psel && !penable && !pwrite;
   endsequence

   sequence s_wr_one;
      psel && penable && pwrite && hit_p1;
   endsequence

   property p_wr_one;
      @(posedge pclk) disable iff (!presetn)
      s_wr_one |=> (port_one_control_two_reg == $past(pwdata));
   endproperty
   a_wr_one: assert property (p_wr_one)
      else $error("port one control write lost");

   property p_wr_two;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && hit_p2) |=>
      (port_two_control_two_reg == $past(pwdata));
   endproperty
   a_wr_two: assert property (p_wr_two)
      else $error("port two control write lost");

   property p_rd_data;
      @(posedge pclk) disable iff (!presetn)
      s_rd_setup ##1 s_apb_access |-> (prdata == $past(rd_mux));
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("read data not from addressed register");

   property p_dec_pulse;
      @(posedge pclk) disable iff (!presetn)
      req_valid |=> dec_valid;
   endproperty
   a_dec_pulse: assert property (p_dec_pulse)
      else $error("decision missing after request");

   property p_bad_drop;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && req_bad && !bad_mirror) |=>
      ((dec_ports == 3'b000) && !dec_mirrored);
   endproperty
   a_bad_drop: assert property (p_bad_drop)
      else $error("bad frame delivered");

   property p_host_trap;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && from_host) |=> !dec_trapped;
   endproperty
   a_host_trap: assert property (p_host_trap)
      else $error("host frame trapped");

   property p_no_reflect;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && !from_host && !mir_go) |=>
      ((dec_ports & $past(src_1h)) == 3'b000);
   endproperty
   a_no_reflect: assert property (p_no_reflect)
      else $error("frame sent back to its source port");

   property p_static_mc;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && mc_static && !trap && !mir_go) |=>
      ((dec_ports & ~$past(req_static_ports)) == 3'b000);
   endproperty
   a_static_mc: assert property (p_static_mc)
      else $error("multicast left the listed ports");

   property p_learn_on;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && req_src == SSM_PORT_P1 && !req_bad &&
       !port_one_control_two_reg[`SSM_BIT_LRNDIS]) |=> dec_learn;
   endproperty
   a_learn_on: assert property (p_learn_on)
      else $error("learning missing with learn enabled");

   property p_host_learn;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && from_host) |=> !dec_learn;
   endproperty
   a_host_learn: assert property (p_host_learn)
      else $error("host frame learned");

   property p_rx_off;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && req_src == SSM_PORT_P1 && !rx_ok[0] && !ovr_host &&
       !trap && !mir_go) |=> (dec_ports == 3'b000);
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("frame passed from a port not receiving");

   property p_tx_two;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && !tx_ok[1] && !mir_go) |=> !dec_ports[1];
   endproperty
   a_tx_two: assert property (p_tx_two)
      else $error("port two sent while transmit disabled");

   property p_src_one;
      @(posedge pclk) disable iff (!presetn)
      (req_valid && req_src == SSM_PORT_P1) |=>
      (rx_source_port_field == 2'b01);
   endproperty
   a_src_one: assert property (p_src_one)
      else $error("wrong source code for port one");
endmodule : ssm_policy

// ---- src/ssm_cfg.svh ----
// Offsets, field positions and reset values of the forwarding-policy block.
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
`define SSM_OFF_PONE_CTL 12'h000
`define SSM_OFF_PTWO_CTL 12'h004
`define SSM_OFF_HPCR2 12'h008
`define SSM_OFF_GCR2 12'h00c
`define SSM_OFF_STAT 12'h010
`define SSM_BIT_TXEN 2
`define SSM_BIT_RXEN 1
`define SSM_BIT_LRNDIS 0
`define SSM_BIT_RXSNIFF 7
`define SSM_BIT_TXSNIFF 6
`define SSM_BIT_SNIFFER 5
`define SSM_BIT_AND 8
`define SSM_BIT_BADMIR 9
`define SSM_BIT_MLDOPT 12
`define SSM_BIT_MLDEN 13
`define SSM_RST_PCR2 32'h0000_0006
`define SSM_RST_GCR2 32'h0000_0000
`define SSM_IPV4 4'h4
`define SSM_PROT_IGMP 8'h02
`define SSM_SRC_P1 2'h1
`define SSM_SRC_P2 2'h2
`endif

// ---- src/ssm_pkg.sv ----
// Types shared by the forwarding-policy block.
package ssm_pkg;
   typedef enum logic [1:0] {
      SSM_PORT_P1 = 2'b00,
      SSM_PORT_P2 = 2'b01,
      SSM_PORT_HOST = 2'b10
   } ssm_port_t;
   typedef enum logic [2:0] {
      SSM_ST_DISABLE = 3'b000,
      SSM_ST_BLOCK = 3'b001,
      SSM_ST_LEARN = 3'b010,
      SSM_ST_FWD = 3'b011,
      SSM_ST_ODD = 3'b100
   } ssm_stp_t;
endpackage : ssm_pkg

// ---- dv/ssm_pkt_src.sv ----
// Lookup-request source that stands in for the switch front end.
`timescale 1ns/1ps
module ssm_pkt_src (
   // Clock.
   input wire logic pclk,
   // Packet descriptor toward the policy block.
   output logic req_valid,
   output logic [1:0] req_src,
   output logic [2:0] req_lookup_ports,
   output logic req_static_hit,
   output logic req_static_override,
   output logic [2:0] req_static_ports,
   output logic req_multicast,
   output logic req_bad,
   output logic req_ipv4,
   output logic [3:0] req_ip_version,
   output logic [7:0] req_ip_protocol,
   output logic req_ipv6,
   output logic [7:0] req_hop_limit,
   output logic [7:0] req_next_header,
   output logic [7:0] req_hbh_next_header
);
   logic [49:0] fld;
   assign {req_src, req_lookup_ports, req_static_hit, req_static_override,
      req_static_ports, req_multicast, req_bad, req_ipv4, req_ip_version,
      req_ip_protocol, req_ipv6, req_hop_limit, req_next_header,
      req_hbh_next_header} = fld;
   initial begin
      req_valid = 1'b0;
      fld = '0;
   end
   // Fields are inverted once released, so a stale descriptor cannot pass.
   task automatic send(input logic [49:0] d);
      @(posedge pclk);
      req_valid <= 1'b1;
      fld <= d;
      @(posedge pclk);
      req_valid <= 1'b0;
      fld <= ~d;
   endtask : send
endmodule : ssm_pkt_src

// ---- dv/ssm_policy_tb_top.sv ----
// Self-checking bench for the forwarding-policy block.
`timescale 1ns/1ps
`include "ssm_cfg.svh"
module ssm_policy_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic req_valid, req_static_hit, req_static_override, req_multicast;
   logic req_bad, req_ipv4, req_ipv6, dec_valid, dec_learn, dec_trapped;
   logic dec_mirrored, sh, so, mc, bad, v4, v6;
   logic [1:0] req_src, rx_source_port_field;
   logic [2:0] req_lookup_ports, req_static_ports, dec_ports, sp;
   logic [3:0] req_ip_version, ver;
   logic [7:0] req_ip_protocol, req_hop_limit, req_next_header, prot;
   logic [7:0] req_hbh_next_header, hop, nh, hbh;
   logic [7:0] codes [5] = '{8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c};
   logic [2:0] stp [3] = '{3'h1, 3'h0, 3'h6};
   logic [3:0] sexp [3] = '{4'h0, 4'h1, 4'h5};
   localparam logic [5:0] TRAP = 6'b100110;
   localparam logic [5:0] PASS = 6'b010100;
   int fail_count = 0;
   int n_checks = 0;
   int i;
   ssm_policy uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_src,
      .req_lookup_ports, .req_static_hit, .req_static_override,
      .req_static_ports, .req_multicast, .req_bad, .req_ipv4,
      .req_ip_version, .req_ip_protocol, .req_ipv6, .req_hop_limit,
      .req_next_header, .req_hbh_next_header, .dec_valid, .dec_ports,
      .dec_learn, .dec_trapped, .dec_mirrored, .rx_source_port_field);
   ssm_pkt_src src (.pclk, .req_valid, .req_src, .req_lookup_ports,
      .req_static_hit, .req_static_override, .req_static_ports,
      .req_multicast, .req_bad, .req_ipv4, .req_ip_version,
      .req_ip_protocol, .req_ipv6, .req_hop_limit, .req_next_header,
      .req_hbh_next_header);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fail_count++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Extra descriptor fields are cleared after each packet.
   task automatic go(input logic [1:0] s, input logic [2:0] lk);
      int n;
      src.send({s, lk, sh, so, sp, mc, bad, v4, ver, prot, v6, hop, nh, hbh});
      n = 0;
      #1;
      while (dec_valid !== 1'b1 && n < 4) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (dec_valid !== 1'b1) begin
         fail_count++;
         final_report();
      end
      {sh, so, mc, bad, v4, v6, sp, ver, prot, hop, nh, hbh} = '0;
   endtask : go
   task automatic pkt(input logic [1:0] s, input logic [2:0] lk,
         input logic [5:0] e);
      go(s, lk);
      cmp({dec_ports, dec_learn, dec_trapped, dec_mirrored}, e);
   endtask : pkt
   task automatic mld(input logic [7:0] a, input logic [7:0] b,
         input logic [7:0] h, input logic [5:0] e);
      v6 = 1'b1;
      mc = 1'b1;
      hop = h;
      nh = a;
      hbh = b;
      pkt(2'd0, 3'b010, e);
   endtask : mld
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {sh, so, mc, bad, v4, v6, sp, ver, prot, hop, nh, hbh} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SSM_OFF_PONE_CTL, 32'h0);
      cmp(rd, `SSM_RST_PCR2);
      apb(1'b0, `SSM_OFF_GCR2, 32'h0);
      cmp(rd, `SSM_RST_GCR2);
      apb(1'b0, 12'h014, 32'h0);
      cmp({31'h0, err}, 32'h1);
      apb(1'b1, `SSM_OFF_PTWO_CTL, 32'h0000_00c6);
      apb(1'b0, `SSM_OFF_PTWO_CTL, 32'h0);
      cmp(rd, 32'h0000_00c6);
      apb(1'b1, `SSM_OFF_PTWO_CTL, 32'h0000_0006);
      // Only port-one traffic is offered while port one steps through blocking, learning and forwarding.
      for (i = 0; i < 3; i++) begin
         apb(1'b1, `SSM_OFF_PONE_CTL, {29'h0, stp[i]});
         pkt(2'd0, 3'b010, {sexp[i], 2'b00});
      end
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0001);
      {sh, so, sp} = {2'b11, 3'b100};
      pkt(2'd0, 3'b010, 6'b100000);
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0000);
      {sh, so, sp} = {2'b11, 3'b100};
      pkt(2'd0, 3'b010, 6'b100100);
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0006);
      apb(1'b1, `SSM_OFF_HPCR2, 32'h0000_0000);
      pkt(2'd1, 3'b100, 6'b100100);
      {v4, ver, prot} = {1'b1, 4'h4, 8'h02};
      pkt(2'd0, 3'b010, TRAP);
      cmp({30'h0, rx_source_port_field}, 32'h1);
      {v4, ver, prot} = {1'b1, 4'h4, 8'h06};
      pkt(2'd0, 3'b010, PASS);
      {v4, ver, prot} = {1'b1, 4'h6, 8'h02};
      pkt(2'd0, 3'b010, PASS);
      pkt(2'd1, 3'b001, 6'b001100);
      cmp({30'h0, rx_source_port_field}, 32'h2);
      {mc, sh, sp} = {2'b11, 3'b001};
      pkt(2'd1, 3'b101, 6'b001100);
      mld(8'h3a, 8'h00, 8'h01, PASS);
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_2000);
      mld(8'h3a, 8'h00, 8'h01, TRAP);
      mld(8'h01, 8'h00, 8'h01, TRAP);
      mld(8'h00, 8'h3a, 8'h01, TRAP);
      mld(8'h00, 8'h01, 8'h01, TRAP);
      mld(8'h3a, 8'h00, 8'h02, PASS);
      for (i = 0; i < 5; i++) begin
         mld(codes[i], 8'h00, 8'h01, PASS);
      end
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_3000);
      for (i = 0; i < 5; i++) begin
         mld(codes[i], 8'h00, 8'h01, TRAP);
         mld(8'h00, codes[i], 8'h01, TRAP);
      end
      // One IGMP, four MLD and ten option traps so far.
      apb(1'b0, `SSM_OFF_STAT, 32'h0);
      cmp(rd, 32'h0000_000f);
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_0000);
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0086);
      apb(1'b1, `SSM_OFF_HPCR2, 32'h0000_0020);
      pkt(2'd0, 3'b010, 6'b110101);
      pkt(2'd0, 3'b100, 6'b100101);
      bad = 1'b1;
      go(2'd0, 3'b010);
      cmp({dec_ports, dec_mirrored}, 4'b0000);
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_0200);
      bad = 1'b1;
      go(2'd0, 3'b010);
      cmp({dec_ports, dec_mirrored}, 4'b1001);
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_0000);
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0046);
      pkt(2'd1, 3'b001, 6'b101101);
      apb(1'b1, `SSM_OFF_PONE_CTL, 32'h0000_0086);
      apb(1'b1, `SSM_OFF_HPCR2, 32'h0000_0000);
      apb(1'b1, `SSM_OFF_PTWO_CTL, 32'h0000_0026);
      pkt(2'd0, 3'b100, 6'b110101);
      apb(1'b1, `SSM_OFF_GCR2, 32'h0000_0100);
      apb(1'b1, `SSM_OFF_PTWO_CTL, 32'h0000_0046);
      apb(1'b1, `SSM_OFF_HPCR2, 32'h0000_0020);
      pkt(2'd0, 3'b010, 6'b110101);
      pkt(2'd0, 3'b100, 6'b100100);
      pkt(2'd1, 3'b001, 6'b001100);
      final_report();
   end
endmodule : ssm_policy_tb_top
